// [logic/mbpd_params.svh]
// Constants for the mode button press decoder: timing, lamp and serial format.
// Assumes a 20 MHz system clock; included by the debounce and top modules, not by the package.
// Functional notes
// - A hold of two to ten seconds, then release, restarts the device into serial setup mode.
// - While the button is held, the ready lamp flashes three times per second.
// - After release into setup mode, the ready lamp flashes once per second for five seconds.
// - In serial setup mode the ready lamp is off and the first-port lamp is on.
// - A hold shorter than two seconds, then release, causes a hardware reset.
// - During hardware reset the first-port lamp is on and the ready lamp is off.
// - A hold longer than ten seconds selects the factory-default state.
// - In the factory-default state both lamps are on.
// - Entering the factory-default state overwrites all stored settings with defaults.
// - In serial setup mode a two-second hold returns the device to normal operation.
// - Serial setup uses 115200 baud, eight data bits, no parity and one stop bit.
// - On return to normal operation all lamps show their normal indications.
// - Without an address server the device falls back to 169.254.102.39.
`ifndef MBPD_PARAMS_SVH
`define MBPD_PARAMS_SVH
`define MBPD_CLK_HZ        20_000_000
`define MBPD_TICK_HZ       1000
`define MBPD_DEBOUNCE_MS   20
`define MBPD_SETUP_MIN_MS  2000
`define MBPD_SETUP_MAX_MS  10000
`define MBPD_EXIT_HOLD_MS  2000
`define MBPD_FAST_HALF_MS  167
`define MBPD_SLOW_HALF_MS  500
`define MBPD_REBOOT_MS     5000
`define MBPD_HWRESET_MS    1000
`define MBPD_DEFAULT_MS    1000
`define MBPD_BAUD          115200
`define MBPD_DATA_BITS     8
`define MBPD_STOP_BITS     1
`define MBPD_PARITY_EN     1'b0
`define MBPD_FALLBACK_IP   32'hA9FE_6627
`endif

// [logic/mbpd_pkg.sv]
// Types shared by the mode button press decoder modules.
// Assumes the params header is on the include path.
package mbpd_pkg;
	typedef enum logic [2:0] {
		MBPD_NORMAL,
		MBPD_PRESSED,
		MBPD_HWRESET,
		MBPD_REBOOT,
		MBPD_SETUP,
		MBPD_SETUP_HELD,
		MBPD_DEFAULTS
	} mbpd_state_e;
	typedef logic [13:0] mbpd_ms_t;
endpackage

// [logic/mbpd_debounce.sv]
// Button debouncer with millisecond tick; output changes after a stable level.
// Assumes the raw button is synchronous to mclk and active low.
`timescale 1ns/1ns
`include "mbpd_params.svh"
module mbpd_debounce
	import mbpd_pkg::*;
#(
	parameter int STABLE_MS = `MBPD_DEBOUNCE_MS
) (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic ce,
	input  wire logic tick,
	input  wire logic btn_n,
	output logic      pressed
);
	// Elaboration check: the filter counter is eight bits wide
	if (STABLE_MS < 1 || STABLE_MS > 255) begin : g_bad_stable
		$error("STABLE_MS out of range");
	end
	logic [7:0] cnt_q;
	// Count stable ticks while raw level differs from the filtered one
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q   <= 8'h00;
			pressed <= 1'b0;
		end else if (ce) begin
			if ((!btn_n) == pressed) begin
				cnt_q <= 8'h00;
			end else if (tick) begin
				if (cnt_q == 8'(STABLE_MS - 1)) begin
					pressed <= !btn_n;
					cnt_q   <= 8'h00;
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end
endmodule

// [logic/mbpd_top.sv]
// Mode button press decoder: classifies hold time and drives the two panel lamps.
// Assumes one 20 MHz clock, asynchronous active-low reset, button synchronous to mclk.
`timescale 1ns/1ns
`include "mbpd_params.svh"
module mbpd_top
	import mbpd_pkg::*;
#(
	parameter int TICK_DIV = `MBPD_CLK_HZ / `MBPD_TICK_HZ
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        btn_n,
	input  wire logic        dhcp_failed,
	output logic             ready_lamp,
	output logic             first_port_lamp,
	output logic             hw_reset_req,
	output logic             load_defaults,
	output logic             setup_mode,
	output logic [31:0]      fallback_ip,
	output logic             fallback_ip_valid,
	output logic [17:0]      setup_baud,
	output logic [3:0]       setup_data_bits,
	output logic             setup_parity_en,
	output logic [1:0]       setup_stop_bits
);
	// Elaboration checks: the prescaler is 16 bits and the millisecond counters 14 bits wide
	if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_div
		$error("TICK_DIV out of range");
	end
	if (`MBPD_SETUP_MAX_MS >= 16383 || `MBPD_REBOOT_MS >= 16383) begin : g_bad_ms
		$error("Millisecond limit too large for the hold counter");
	end

	// Limits in milliseconds; the hold counter saturates at 16383 so the defaults band stays reachable
	localparam mbpd_ms_t SETUP_MIN = 14'(`MBPD_SETUP_MIN_MS);
	localparam mbpd_ms_t SETUP_MAX = 14'(`MBPD_SETUP_MAX_MS);
	localparam mbpd_ms_t EXIT_HOLD = 14'(`MBPD_EXIT_HOLD_MS);
	localparam mbpd_ms_t FAST_HALF = 14'(`MBPD_FAST_HALF_MS);
	localparam mbpd_ms_t SLOW_HALF = 14'(`MBPD_SLOW_HALF_MS);
	localparam mbpd_ms_t REBOOT_MS = 14'(`MBPD_REBOOT_MS);
	localparam mbpd_ms_t HWRST_MS  = 14'(`MBPD_HWRESET_MS);
	localparam mbpd_ms_t DEFLT_MS  = 14'(`MBPD_DEFAULT_MS);

	// Prescaler, filtered button, sequencer and flash state
	logic [15:0] pre_q;
	logic        tick;
	logic        pressed;
	logic        pressed_q;
	mbpd_state_e state_q;
	mbpd_ms_t    hold_q;
	mbpd_ms_t    dwell_q;
	mbpd_ms_t    flash_q;
	logic        flash_on_q;
	logic        fall;
	logic        rise;

	// Millisecond prescaler; all timing runs from this one tick
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= 16'h0000;
		end else if (ce) begin
			if (pre_q == 16'(TICK_DIV - 1)) begin
				pre_q <= 16'h0000;
			end else begin
				pre_q <= pre_q + 16'h0001;
			end
		end
	end
	// Tick is gated by the enable so a frozen block loses no time
	assign tick = ce && (pre_q == 16'(TICK_DIV - 1));

	// Filter contact bounce before any hold timing starts
	mbpd_debounce u_deb (
		.mclk    (mclk),
		.nrst    (nrst),
		.ce      (ce),
		.tick    (tick),
		.btn_n   (btn_n),
		.pressed (pressed)
	);

	// Edge detection on the filtered button
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pressed_q <= 1'b0;
		end else if (ce) begin
			pressed_q <= pressed;
		end
	end
	// Each edge lasts one cycle; the sequencer acts on it directly
	assign rise = pressed && !pressed_q;
	assign fall = !pressed && pressed_q;

	// Hold timer saturates so very long presses stay in the defaults band
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= 14'h0000;
		end else if (ce) begin
			if (rise) begin
				hold_q <= 14'h0000;
			end else if (pressed && tick && hold_q != 14'h3FFF) begin
				hold_q <= hold_q + 14'h0001;
			end
		end
	end

	// Press classifier and mode sequencer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= MBPD_NORMAL;
			dwell_q <= 14'h0000;
		end else if (ce) begin
			if (tick && dwell_q != 14'h3FFF) begin
				dwell_q <= dwell_q + 14'h0001;
			end
			case (state_q)
				MBPD_NORMAL: begin
					if (rise) begin
						state_q <= MBPD_PRESSED;
					end
				end
				MBPD_PRESSED: begin
					if (fall) begin
						dwell_q <= 14'h0000;
						if (hold_q < SETUP_MIN) begin
							state_q <= MBPD_HWRESET;
						end else if (hold_q <= SETUP_MAX) begin
							state_q <= MBPD_REBOOT;
						end else begin
							state_q <= MBPD_DEFAULTS;
						end
					end
				end
				MBPD_HWRESET: begin
					if (dwell_q >= HWRST_MS) begin
						state_q <= MBPD_NORMAL;
					end
				end
				MBPD_REBOOT: begin
					if (dwell_q >= REBOOT_MS) begin
						state_q <= MBPD_SETUP;
					end
				end
				MBPD_SETUP: begin
					if (rise) begin
						state_q <= MBPD_SETUP_HELD;
					end
				end
				MBPD_SETUP_HELD: begin
					if (hold_q >= EXIT_HOLD) begin
						state_q <= MBPD_NORMAL;
					end else if (fall) begin
						state_q <= MBPD_SETUP;
					end
				end
				MBPD_DEFAULTS: begin
					if (dwell_q >= DEFLT_MS) begin
						state_q <= MBPD_NORMAL;
					end
				end
				default: begin
					state_q <= MBPD_NORMAL;
				end
			endcase
		end
	end

	// Flash generator: half-period counter gives an even duty cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flash_q    <= 14'h0000;
			flash_on_q <= 1'b0;
		end else if (ce) begin
			if (rise || fall) begin
				flash_q    <= 14'h0000;
				flash_on_q <= 1'b1;
			end else if (tick) begin
				if (flash_q >= ((state_q == MBPD_REBOOT) ? SLOW_HALF : FAST_HALF) - 14'h0001) begin
					flash_q    <= 14'h0000;
					flash_on_q <= !flash_on_q;
				end else begin
					flash_q <= flash_q + 14'h0001;
				end
			end
		end
	end

	// Lamp drive per state; normal operation shows ready on, port lamp idle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ready_lamp      <= 1'b1;
			first_port_lamp <= 1'b0;
		end else if (ce) begin
			case (state_q)
				MBPD_PRESSED, MBPD_SETUP_HELD: begin
					ready_lamp      <= flash_on_q;
					first_port_lamp <= (state_q == MBPD_SETUP_HELD);
				end
				MBPD_REBOOT: begin
					ready_lamp      <= flash_on_q;
					first_port_lamp <= 1'b0;
				end
				MBPD_SETUP: begin
					ready_lamp      <= 1'b0;
					first_port_lamp <= 1'b1;
				end
				MBPD_HWRESET: begin
					ready_lamp      <= 1'b0;
					first_port_lamp <= 1'b1;
				end
				MBPD_DEFAULTS: begin
					ready_lamp      <= 1'b1;
					first_port_lamp <= 1'b1;
				end
				default: begin
					ready_lamp      <= 1'b1;
					first_port_lamp <= 1'b0;
				end
			endcase
		end
	end

	// Action strobes; load_defaults pulses once on entry so storage is rewritten once
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hw_reset_req  <= 1'b0;
			load_defaults <= 1'b0;
			setup_mode    <= 1'b0;
		end else if (ce) begin
			hw_reset_req  <= (state_q == MBPD_HWRESET);
			load_defaults <= (state_q == MBPD_PRESSED) && fall && (hold_q > SETUP_MAX);
			setup_mode    <= (state_q == MBPD_SETUP) || (state_q == MBPD_SETUP_HELD);
		end
	end

	// Fixed serial format and fallback address; zero in reset, constant from the first enabled cycle, while the valid flag follows dhcp_failed
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			setup_baud        <= 18'h0_0000;
			setup_data_bits   <= 4'h0;
			setup_parity_en   <= 1'b0;
			setup_stop_bits   <= 2'h0;
			fallback_ip       <= 32'h0000_0000;
			fallback_ip_valid <= 1'b0;
		end else if (ce) begin
			setup_baud        <= 18'(`MBPD_BAUD);
			setup_data_bits   <= 4'(`MBPD_DATA_BITS);
			setup_parity_en   <= `MBPD_PARITY_EN;
			setup_stop_bits   <= 2'(`MBPD_STOP_BITS);
			fallback_ip       <= `MBPD_FALLBACK_IP;
			fallback_ip_valid <= dhcp_failed;
		end
	end

	// Checks: lamp patterns in the normal, pressed, hardware reset, setup and defaults states, band decisions, strobe shape and the fixed serial format
	a_hwreset_lamps: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_HWRESET |=> !ce || (first_port_lamp && !ready_lamp))
		else $error("hw reset lamps wrong");
	a_setup_lamps: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_SETUP |=> !ce || (first_port_lamp && !ready_lamp))
		else $error("setup lamps wrong");
	a_default_lamps: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_DEFAULTS |=> !ce || (first_port_lamp && ready_lamp))
		else $error("default lamps wrong");
	a_short_reset: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_PRESSED && fall && hold_q < SETUP_MIN |=> state_q == MBPD_HWRESET)
		else $error("short press did not reset");
	a_band_setup: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_PRESSED && fall && hold_q >= SETUP_MIN && hold_q <= SETUP_MAX
		|=> state_q == MBPD_REBOOT)
		else $error("band press did not reboot");
	a_long_default: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_PRESSED && fall && hold_q > SETUP_MAX
		|=> state_q == MBPD_DEFAULTS && load_defaults)
		else $error("long press did not load defaults");
	a_load_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		ce && load_defaults |=> !load_defaults)
		else $error("defaults strobe not single");
	a_setup_exit: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_SETUP_HELD && hold_q >= EXIT_HOLD |=> state_q == MBPD_NORMAL)
		else $error("setup exit failed");
	a_normal_lamps: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_NORMAL |=> !ce || (ready_lamp && !first_port_lamp))
		else $error("normal lamps wrong");
	a_serial_fmt: assert property (@(posedge mclk) disable iff (!nrst)
		$past(ce) && $past(nrst) |-> setup_baud == 18'(`MBPD_BAUD) && setup_data_bits == 4'(`MBPD_DATA_BITS)
		&& setup_parity_en == `MBPD_PARITY_EN && setup_stop_bits == 2'(`MBPD_STOP_BITS))
		else $error("serial format wrong");
	a_press_flash: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_PRESSED |=> !ce || (ready_lamp == $past(flash_on_q) && flash_q < FAST_HALF))
		else $error("press flash wrong");
	a_reboot_hold: assert property (@(posedge mclk) disable iff (!nrst)
		ce && state_q == MBPD_REBOOT && dwell_q < REBOOT_MS |=> state_q == MBPD_REBOOT)
		else $error("reboot flashing cut short");

	// Coverage of the main scenarios
	c_short_press: cover property (@(posedge mclk) disable iff (!nrst) state_q == MBPD_HWRESET);
	c_reboot_dark: cover property (@(posedge mclk) disable iff (!nrst) state_q == MBPD_REBOOT && !ready_lamp);
	c_setup_entry: cover property (@(posedge mclk) disable iff (!nrst) state_q == MBPD_SETUP);
	c_defaults:    cover property (@(posedge mclk) disable iff (!nrst) load_defaults);
	c_setup_leave: cover property (@(posedge mclk) disable iff (!nrst)
		state_q == MBPD_SETUP_HELD ##1 state_q == MBPD_NORMAL);
endmodule

// [sim/mbpd_operator.sv]
// Operator model: presses the panel button with contact bounce, then releases it cleanly.
// Assumes the bench calls push from its sequence; the button line idles high on its pull-up.
`timescale 1ns/1ns
module mbpd_operator #(
	parameter int MS_CYC = 2
) (
	input  wire logic mclk,
	output logic      btn_n
);
	initial btn_n = 1'b1;

	// Four 3 ms bounces first, so the hold is timed from the steady low edge
	task automatic push(input int hold_ms);
		@(posedge mclk);
		#2 btn_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			repeat (3 * MS_CYC) @(posedge mclk);
			#2 btn_n = ~btn_n;
		end
		repeat (hold_ms * MS_CYC) @(posedge mclk);
		#2 btn_n = 1'b1;
	endtask
endmodule

// [sim/mode_button_press_decoder_test.sv]
// Self-checking bench for the mode button press decoder: hold classes, lamp patterns, setup format.
// Assumes the operator model drives the button; the prescaler is shortened to 2 cycles a tick.
`timescale 1ns/1ns
module mode_button_press_decoder_test;
	import mbpd_pkg::*;
	localparam int DIV = 2; // Cycles per ms tick, keeps the long holds affordable
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        dhcp_failed = 1'b0;
	logic        btn_n, run;
	logic        ready_lamp, first_port_lamp, hw_reset_req, load_defaults, setup_mode;
	logic        fallback_ip_valid, setup_parity_en;
	logic [31:0] fallback_ip;
	logic [17:0] setup_baud;
	logic [3:0]  setup_data_bits;
	logic [1:0]  setup_stop_bits;
	int          err_count, total_checks, pulses, half;
	int          seed = 55;
	time         t_rel;

	mbpd_top #(.TICK_DIV(DIV)) i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .btn_n(btn_n),
		.dhcp_failed(dhcp_failed), .ready_lamp(ready_lamp), .first_port_lamp(first_port_lamp),
		.hw_reset_req(hw_reset_req), .load_defaults(load_defaults), .setup_mode(setup_mode),
		.fallback_ip(fallback_ip), .fallback_ip_valid(fallback_ip_valid), .setup_baud(setup_baud),
		.setup_data_bits(setup_data_bits), .setup_parity_en(setup_parity_en), .setup_stop_bits(setup_stop_bits));
	mbpd_operator #(.MS_CYC(DIV)) i_op (.mclk(mclk), .btn_n(btn_n));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Hold class: 0 hardware reset, 1 serial setup (both bounds inclusive), 2 factory defaults
	function automatic int mode_of(input int h);
		return (h < 2000) ? 0 : ((h <= 10000) ? 1 : 2);
	endfunction

	task automatic wait_ms(input int n);
		repeat (n * DIV) @(posedge mclk);
		#1;
	endtask

	// Positions a sample n ms after the last release, so flash phase is known
	task automatic at_ms(input int n);
		while ($time < t_rel + n * DIV * 50) @(posedge mclk);
		#1;
	endtask

	// Time between two ready-lamp toggles in ms; a stuck lamp gives the 1000 ms timeout value
	task automatic half_period(output int ms);
		time  t1;
		logic v;
		t1 = 0;
		for (int k = 0; k < 2; k++) begin
			v = ready_lamp;
			for (int n = 0; n < 1000 * DIV && ready_lamp === v; n++) @(posedge mclk) #1;
			if (k == 0) t1 = $time;
		end
		ms = int'(($time - t1) / (DIV * 50));
	endtask

	task automatic press_case(input int h);
		int c;
		int p0;
		c = mode_of(h);
		p0 = pulses;
		fork
			i_op.push(h);
			begin
				wait_ms(150);
				half_period(half);
				check(half, 167);
			end
		join
		t_rel = $time;
		at_ms(40);
		check(hw_reset_req, c == 0);
		check(pulses - p0, c == 2);
		if (c != 1) begin
			check({ready_lamp, first_port_lamp}, {c == 2, 1'b1});
			at_ms(1100);
			check({ready_lamp, first_port_lamp, hw_reset_req}, 3'b100);
		end else begin
			half_period(half);
			check(half, 500);
			at_ms(4250);
			check({ready_lamp, hw_reset_req}, 2'b10);
			at_ms(5100);
			check({ready_lamp, first_port_lamp, setup_mode}, 3'b011);
			// Exit needs no release; the lamps must change while still held
			fork
				i_op.push(2100);
				begin
					wait_ms(1950);
					check({first_port_lamp, setup_mode}, 2'b11);
					wait_ms(140);
					check({ready_lamp, first_port_lamp, setup_mode}, 3'b100);
				end
			join
			// The filter must see the release before the next press starts
			wait_ms(50);
		end
	endtask

	// Address-valid flag trails the server status by one cycle; status is random
	always @(posedge mclk) begin
		#1;
		if (run === 1'b1 && ce === 1'b1) check(fallback_ip_valid, dhcp_failed);
		#1 dhcp_failed = 1'($random(seed));
	end

	// Counts cycles with the defaults strobe high; a proper pulse adds exactly one
	always @(posedge mclk) if (load_defaults === 1'b1) pulses++;

	initial begin
		repeat (3) @(posedge mclk);
		#1;
		check({ready_lamp, first_port_lamp, hw_reset_req, load_defaults, setup_mode}, 5'b1_0000);
		#1 nrst = 1'b1;
		wait_ms(5);
		run = 1'b1;
		check(fallback_ip, 32'hA9FE_6627);
		check({setup_baud, setup_data_bits, setup_parity_en, setup_stop_bits}, {18'h1_C200, 4'h8, 1'b0, 2'h1});
		i_op.push(0);
		wait_ms(100);
		check({ready_lamp, first_port_lamp, hw_reset_req, setup_mode}, 4'b1000);
		// With the enable low a short press must go unseen: no reset, lamps frozen
		#1 ce = 1'b0;
		i_op.push(500);
		wait_ms(40);
		check({ready_lamp, first_port_lamp, hw_reset_req}, 3'b100);
		#1 ce = 1'b1;
		wait_ms(100);
		check({ready_lamp, first_port_lamp, hw_reset_req, setup_mode}, 4'b1000);
		for (int i = 0; i < 2; i++) press_case(700 + {$random(seed)} % 1100);
		press_case(2002);
		press_case(9990);
		press_case(10100);
		wrap_up();
	end

	// Watchdog sized for about 50 s of shortened button time, some 100k cycles
	initial begin
		#5_000_000;
		err_count++;
		wrap_up();
	end
endmodule
